// ---- rtl/adcsq_defines.svh ----
// Offsets, field positions, reset values and cycle counts of the converter sequencer
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

`define ADCSQ_OFF_CTL 8'h30
`define ADCSQ_OFF_RES1 8'h31
`define ADCSQ_OFF_RES4 8'h34
`define ADCSQ_OFF_INT_STAT 8'h35
`define ADCSQ_OFF_INT_MASK 8'h36
`define ADCSQ_OFF_OPTIONS 8'h37

`define ADCSQ_CTL_CCF 7
`define ADCSQ_CTL_SCAN 5
`define ADCSQ_CTL_MULTI_CHANNEL_SELECT 4
`define ADCSQ_CTL_CHAN_HI 3
`define ADCSQ_CTL_CHAN_LO 0
`define ADCSQ_CHAN_GRP_HI 3
`define ADCSQ_CHAN_GRP_LO 2
`define ADCSQ_CTL_RESET 8'h00

`define ADCSQ_INT_DONE 0
`define ADCSQ_INT_ABORT 1
`define ADCSQ_INT_RESET 2'h0
`define ADCSQ_OPT_PUMP 0

`define ADCSQ_ZERO8 8'h00
`define ADCSQ_IDX_FIRST 2'h0
`define ADCSQ_IDX_LAST 2'h3
`define ADCSQ_IDX_STEP 2'h1

`define ADCSQ_SAMPLE_CYCLES 4'hC
`define ADCSQ_SAMPLE_LAST (`ADCSQ_SAMPLE_CYCLES - 4'h1)
`define ADCSQ_BIT_CYCLES 4'h4
`define ADCSQ_BIT_LAST (`ADCSQ_BIT_CYCLES - 4'h1)
`define ADCSQ_CNT_ZERO 4'h0
`define ADCSQ_CNT_STEP 4'h1
`define ADCSQ_BIT_MSB 3'h7
`define ADCSQ_BIT_LSB 3'h0
`define ADCSQ_BIT_STEP 3'h1
`define ADCSQ_CODE_MSB 8'h80

`endif

// ---- rtl/adcsq_pkg.sv ----
// Types shared by the converter sequencer modules
package adcsq_pkg;

  typedef enum logic [1:0] {
    ADCSQ_SEQ_IDLE = 2'h0,
    ADCSQ_SEQ_START = 2'h1,
    ADCSQ_SEQ_CONV = 2'h3,
    ADCSQ_SEQ_ABORT = 2'h2
  } adcsq_seq_type;

  typedef enum logic [1:0] {
    ADCSQ_SAR_IDLE = 2'h0,
    ADCSQ_SAR_SAMPLE = 2'h1,
    ADCSQ_SAR_BITS = 2'h3
  } adcsq_sar_type;

endpackage

// ---- rtl/adcsq_sar.sv ----
// Successive-approximation engine for one 8-bit conversion
`timescale 1ns/1ns
`include "adcsq_defines.svh"

module adcsq_sar
  import adcsq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic abort,
  input wire logic cmp_in,
  output logic sample_en,
  output logic [7:0] dac_code,
  output logic done,
  output logic [7:0] result
);

  adcsq_sar_type st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] code_q, code_d;
  logic [7:0] res_q, res_d;
  logic samp_q, samp_d;
  logic done_q, done_d;
  logic cmp_m_q, cmp_s_q;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    code_d = code_q;
    res_d = res_q;
    samp_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      ADCSQ_SAR_IDLE: begin
        if (start) begin
          st_d = ADCSQ_SAR_SAMPLE;
          cnt_d = `ADCSQ_CNT_ZERO;
          code_d = `ADCSQ_ZERO8;
          samp_d = 1'b1;
        end
      end
      ADCSQ_SAR_SAMPLE: begin
        samp_d = 1'b1;
        cnt_d = cnt_q + `ADCSQ_CNT_STEP;
        if (cnt_q == `ADCSQ_SAMPLE_LAST) begin
          samp_d = 1'b0;
          st_d = ADCSQ_SAR_BITS;
          cnt_d = `ADCSQ_CNT_ZERO;
          bit_d = `ADCSQ_BIT_MSB;
          code_d = `ADCSQ_CODE_MSB;
        end
      end
      ADCSQ_SAR_BITS: begin
        cnt_d = cnt_q + `ADCSQ_CNT_STEP;
        // Settle time covers the two-flop comparator synchroniser
        if (cnt_q == `ADCSQ_BIT_LAST) begin
          cnt_d = `ADCSQ_CNT_ZERO;
          if (!cmp_s_q) begin
            code_d[bit_q] = 1'b0;
          end
          if (bit_q == `ADCSQ_BIT_LSB) begin
            st_d = ADCSQ_SAR_IDLE;
            done_d = 1'b1;
            res_d = code_d;
          end else begin
            bit_d = bit_q - `ADCSQ_BIT_STEP;
            code_d[bit_q - `ADCSQ_BIT_STEP] = 1'b1;
          end
        end
      end
      default: begin
        st_d = ADCSQ_SAR_IDLE;
      end
    endcase
    if (abort) begin
      st_d = ADCSQ_SAR_IDLE;
      cnt_d = `ADCSQ_CNT_ZERO;
      samp_d = 1'b0;
      done_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ADCSQ_SAR_IDLE;
      cnt_q <= `ADCSQ_CNT_ZERO;
      bit_q <= `ADCSQ_BIT_MSB;
      code_q <= `ADCSQ_ZERO8;
      res_q <= `ADCSQ_ZERO8;
      samp_q <= 1'b0;
      done_q <= 1'b0;
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      code_q <= code_d;
      res_q <= res_d;
      samp_q <= samp_d;
      done_q <= done_d;
      cmp_m_q <= cmp_in;
      cmp_s_q <= cmp_m_q;
    end
  end

  assign sample_en = samp_q;
  assign dac_code = code_q;
  assign done = done_q;
  assign result = res_q;

endmodule

// ---- rtl/adcsq_top.sv ----
// Converter sequencer: register port, four-conversion sequences, results and interrupt
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "adcsq_defines.svh"

// Operation
// - Eight-bit successive approximation, no external hold
// - Four-bit select picks one of sixteen inputs
// - Pump clock select drives both charge pumps
// - Conversions always run in groups of four
// - Control write starts a new sequence
// - Write mid-conversion aborts and sets complete flag
// - Scan off: four conversions then stop
// - Scan on: round-robin forever, overwriting results
// - Multi off: one channel, on: group
// - Upper bits pick group, lower bits step
// - Complete flag set at end, cleared by write
// - Input reaches capacitor only twelve sample cycles
// - Codes map inputs, reserved, references, test
module adcsq_top
  import adcsq_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic cmp_in,
  output logic [3:0] mux_sel,
  output logic sample_en,
  output logic [7:0] dac_code,
  output logic pump_clk_sel,
  output logic irq
);

  // Channel driven for the conversion at position idx of the sequence
  function automatic logic [3:0] chan_pick(input logic multi_channel_select, input logic [3:0] sel, input logic [1:0] idx);
    if (multi_channel_select) begin
      chan_pick = {sel[`ADCSQ_CHAN_GRP_HI:`ADCSQ_CHAN_GRP_LO], idx};
    end else begin
      chan_pick = sel;
    end
  endfunction

  adcsq_seq_type st_q, st_d;
  logic [1:0] idx_q, idx_d;
  logic ccf_q, ccf_d;
  logic scan_q, scan_d;
  logic multi_channel_select_q, multi_channel_select_d;
  logic [3:0] sel_q, sel_d;
  logic [3:0] mux_q, mux_d;
  logic [7:0] res_q [4];
  logic [7:0] res_d [4];
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic pump_q, pump_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic wr_ctl;
  logic sar_start;
  logic sar_abort;
  logic sar_done;
  logic [7:0] sar_result;
  logic [1:0] evt;
  logic [1:0] rd_clr;

  assign wr_ctl = bus_wr && (bus_addr == `ADCSQ_OFF_CTL);
  assign sar_start = (st_q == ADCSQ_SEQ_START);
  assign sar_abort = wr_ctl && (st_q != ADCSQ_SEQ_IDLE);

  adcsq_sar u_sar (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .start(sar_start),
    .abort(sar_abort),
    .cmp_in(cmp_in),
    .sample_en(sample_en),
    .dac_code(dac_code),
    .done(sar_done),
    .result(sar_result)
  );

  // Sequencer
  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    ccf_d = ccf_q;
    scan_d = scan_q;
    multi_channel_select_d = multi_channel_select_q;
    sel_d = sel_q;
    evt = 2'h0;
    for (int i = 0; i < 4; i++) begin
      res_d[i] = res_q[i];
    end
    case (st_q)
      ADCSQ_SEQ_IDLE: begin
        if (wr_ctl) begin
          ccf_d = 1'b0;
          idx_d = `ADCSQ_IDX_FIRST;
          st_d = ADCSQ_SEQ_START;
        end
      end
      ADCSQ_SEQ_START: begin
        st_d = ADCSQ_SEQ_CONV;
      end
      ADCSQ_SEQ_CONV: begin
        if (sar_done) begin
          res_d[idx_q] = sar_result;
          if (idx_q == `ADCSQ_IDX_LAST) begin
            ccf_d = 1'b1;
            evt[`ADCSQ_INT_DONE] = 1'b1;
            idx_d = `ADCSQ_IDX_FIRST;
            if (scan_q) begin
              st_d = ADCSQ_SEQ_START;
            end else begin
              st_d = ADCSQ_SEQ_IDLE;
            end
          end else begin
            idx_d = idx_q + `ADCSQ_IDX_STEP;
            st_d = ADCSQ_SEQ_START;
          end
        end
      end
      ADCSQ_SEQ_ABORT: begin
        // Flag shows set for one cycle, then the restart clears it
        ccf_d = 1'b0;
        idx_d = `ADCSQ_IDX_FIRST;
        st_d = ADCSQ_SEQ_START;
      end
      default: begin
        st_d = ADCSQ_SEQ_IDLE;
      end
    endcase
    if (wr_ctl) begin
      scan_d = bus_wdata[`ADCSQ_CTL_SCAN];
      multi_channel_select_d = bus_wdata[`ADCSQ_CTL_MULTI_CHANNEL_SELECT];
      sel_d = bus_wdata[`ADCSQ_CTL_CHAN_HI:`ADCSQ_CTL_CHAN_LO];
      if (st_q != ADCSQ_SEQ_IDLE) begin
        ccf_d = 1'b1;
        evt[`ADCSQ_INT_ABORT] = 1'b1;
        st_d = ADCSQ_SEQ_ABORT;
      end
    end
  end

  // Codes pass straight to the analog mux; reserved codes are not blocked
  always_comb begin
    mux_d = chan_pick(multi_channel_select_q, sel_q, idx_q);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ADCSQ_SEQ_IDLE;
      idx_q <= `ADCSQ_IDX_FIRST;
      ccf_q <= 1'b0;
      scan_q <= 1'b0;
      multi_channel_select_q <= 1'b0;
      sel_q <= 4'h0;
      mux_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= `ADCSQ_ZERO8;
      end
    end else begin
      st_q <= st_d;
      idx_q <= idx_d;
      ccf_q <= ccf_d;
      scan_q <= scan_d;
      multi_channel_select_q <= multi_channel_select_d;
      sel_q <= sel_d;
      mux_q <= mux_d;
      for (int i = 0; i < 4; i++) begin
        res_q[i] <= res_d[i];
      end
    end
  end

  // Register port, options and interrupt
  always_comb begin
    mask_d = mask_q;
    pump_d = pump_q;
    rdata_d = `ADCSQ_ZERO8;
    rd_clr = 2'h0;
    if (bus_wr) begin
      if (bus_addr == `ADCSQ_OFF_INT_MASK) begin
        mask_d = bus_wdata[1:0];
      end else if (bus_addr == `ADCSQ_OFF_OPTIONS) begin
        pump_d = bus_wdata[`ADCSQ_OPT_PUMP];
      end
    end
    if (bus_rd) begin
      if (bus_addr == `ADCSQ_OFF_CTL) begin
        rdata_d[`ADCSQ_CTL_CCF] = ccf_q;
        rdata_d[`ADCSQ_CTL_SCAN] = scan_q;
        rdata_d[`ADCSQ_CTL_MULTI_CHANNEL_SELECT] = multi_channel_select_q;
        rdata_d[`ADCSQ_CTL_CHAN_HI:`ADCSQ_CTL_CHAN_LO] = sel_q;
      end else if (bus_addr >= `ADCSQ_OFF_RES1 && bus_addr <= `ADCSQ_OFF_RES4) begin
        rdata_d = res_q[2'(bus_addr - `ADCSQ_OFF_RES1)];
      end else if (bus_addr == `ADCSQ_OFF_INT_STAT) begin
        rdata_d[1:0] = stat_q;
        rd_clr = 2'h3;
      end else if (bus_addr == `ADCSQ_OFF_INT_MASK) begin
        rdata_d[1:0] = mask_q;
      end else if (bus_addr == `ADCSQ_OFF_OPTIONS) begin
        rdata_d[`ADCSQ_OPT_PUMP] = pump_q;
      end
    end
    // A new event in the clearing read's cycle survives
    stat_d = (stat_q & ~rd_clr) | evt;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= `ADCSQ_INT_RESET;
      mask_q <= `ADCSQ_INT_RESET;
      pump_q <= 1'b0;
      rdata_q <= `ADCSQ_ZERO8;
      irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      pump_q <= pump_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign mux_sel = mux_q;
  // Slow bus clocks need this set by software to avoid charge loss
  assign pump_clk_sel = pump_q;
  assign irq = irq_q;

endmodule

// ---- bench/adcsq_monitor.sv ----
// Port checker of the converter sequencer
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module adcsq_monitor (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic [3:0] mux_sel,
  input wire logic sample_en,
  input wire logic [7:0] dac_code,
  input wire logic pump_clk_sel
);
  logic wr_ctl;
  logic [7:0] ctl_q, ctl_d, rises_q, rises_d, age_q, age_d;
  logic [3:0] scnt_q, scnt_d;
  assign wr_ctl = bus_wr && bus_addr == `ADCSQ_OFF_CTL;
  // Age since last control write, so aborted windows are not judged
  always_comb begin
    ctl_d = wr_ctl ? bus_wdata : ctl_q;
    scnt_d = sample_en ? scnt_q + 4'h1 : 4'h0;
    rises_d = wr_ctl ? 8'h00 : rises_q + {7'h00, sample_en && scnt_q == 4'h0};
    age_d = wr_ctl ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= 8'h00;
      scnt_q <= 4'h0;
      rises_q <= 8'h00;
      age_q <= 8'h00;
    end else begin
      ctl_q <= ctl_d;
      scnt_q <= scnt_d;
      rises_q <= rises_d;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_full_sample;
    $fell(sample_en) && age_q >= 8'h0E;
  endsequence
  sequence s_quiet;
    (!wr_ctl)[*4];
  endsequence
  AST_SAMPLE_MAX: assert property (scnt_q <= 4'hC) else $error("sample window too long");
  AST_SAMPLE_LEN: assert property (s_full_sample |-> scnt_q == 4'hC) else $error("sample window short");
  AST_FIRST_TRIAL: assert property (s_full_sample |-> dac_code == 8'h80) else $error("bad first trial");
  AST_NEXT_TRIAL: assert property (s_full_sample ##0 s_quiet |=> dac_code[6] && dac_code[5:0] == 6'h00)
    else $error("bad second trial");
  AST_RESTART: assert property (wr_ctl |-> ##[2:6] sample_en) else $error("no restart");
  AST_FLAG_CLEAR: assert property (wr_ctl ##4 (bus_rd && bus_addr == `ADCSQ_OFF_CTL) |=> !bus_rdata[7])
    else $error("flag not cleared");
  AST_READBACK: assert property ($past(bus_rd) && $past(bus_addr) == `ADCSQ_OFF_CTL
    |-> bus_rdata[6:0] == {1'b0, ctl_q[5:0]}) else $error("control readback wrong");
  AST_FOUR_ONLY: assert property (!ctl_q[5] |-> rises_q <= 8'h04) else $error("too many conversions");
  AST_MUX: assert property ($rose(sample_en)
    |-> mux_sel == (ctl_q[4] ? {ctl_q[3:2], rises_q[1:0]} : ctl_q[3:0])) else $error("wrong channel");
  AST_PUMP: assert property (bus_wr && bus_addr == `ADCSQ_OFF_OPTIONS
    |=> pump_clk_sel == $past(bus_wdata[0])) else $error("pump select wrong");
endmodule

// ---- bench/tb_adcsq_top.sv ----
// Self-checking bench of the converter sequencer
`timescale 1ns/1ns
`include "adcsq_defines.svh"
module tb_adcsq_top;
  localparam logic [7:0] a_ctl = `ADCSQ_OFF_CTL;
  localparam logic [7:0] a_res1 = `ADCSQ_OFF_RES1;
  localparam logic [7:0] a_stat = `ADCSQ_OFF_INT_STAT;
  localparam logic [7:0] a_opt = `ADCSQ_OFF_OPTIONS;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, offs = 8'h00, rv;
  logic bus_wr = 1'b0, bus_rd = 1'b0;
  logic [7:0] bus_rdata, dac_code;
  logic [3:0] mux_sel;
  logic sample_en, pump_clk_sel, irq, cmp_in;
  int miscompares = 0, comparisons = 0;
  // Ideal comparator; every input has its own level
  function automatic logic [7:0] vin(input logic [3:0] c);
    return {c, 4'hA} ^ offs;
  endfunction
  assign cmp_in = vin(mux_sel) >= dac_code;
  always #5 ref_clk = ~ref_clk;
  adcsq_top dut (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cmp_in(cmp_in), .mux_sel(mux_sel),
    .sample_en(sample_en), .dac_code(dac_code), .pump_clk_sel(pump_clk_sel), .irq(irq));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    // Let the strobe's edge settle before any direct output compare
    #1;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1 rv = bus_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, e);
  endtask
  // Bounded poll; a bound that runs out ends the run
  task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    int n;
    n = 0;
    rd(a);
    while ((rv & m) !== e && n < 600) begin
      rd(a);
      n++;
    end
    chk(rv & m, e);
    if (n >= 600) conclude();
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    rchk(a_ctl, 8'h00);
    wr(`ADCSQ_OFF_INT_MASK, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wr(a_ctl, 8'h05);
    repeat (2) @(posedge ref_clk);
    rchk(a_ctl, 8'h05);
    poll(a_ctl, 8'h80, 8'h80);
    rchk(a_ctl, 8'h85);
    for (int i = 0; i < 4; i++) rchk(a_res1 + 8'(i), vin(4'h5));
    chk({7'h00, irq}, 8'h01);
    rchk(a_stat, 8'h01);
    rchk(a_stat, 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("Test single done");
    for (int g = 0; g < 4; g++) begin
      wr(a_ctl, 8'h10 | 8'(g << 2));
      poll(a_ctl, 8'h80, 8'h80);
      for (int i = 0; i < 4; i++) rchk(a_res1 + 8'(i), vin(4'(g * 4 + i)));
    end
    $display("Test groups done");
    rd(a_stat);
    wr(a_ctl, 8'h1F);
    // Lands inside the first conversion
    repeat (20) @(posedge ref_clk);
    wr(a_ctl, 8'h01);
    poll(a_ctl, 8'h80, 8'h80);
    rchk(a_stat, 8'h03);
    for (int i = 0; i < 4; i++) rchk(a_res1 + 8'(i), vin(4'h1));
    $display("Test abort done");
    wr(a_ctl, 8'h22);
    poll(a_res1, 8'hFF, vin(4'h2));
    offs = 8'h05;
    poll(`ADCSQ_OFF_RES4, 8'hFF, vin(4'h2));
    poll(a_res1, 8'hFF, vin(4'h2));
    wr(a_res1, 8'hFF);
    rchk(a_res1, vin(4'h2));
    rchk(8'h3F, 8'h00);
    wr(a_opt, 8'h01);
    chk({7'h00, pump_clk_sel}, 8'h01);
    rchk(a_opt, 8'h01);
    wr(a_opt, 8'h00);
    chk({7'h00, pump_clk_sel}, 8'h00);
    $display("Test scan and options done");
    conclude();
  end
endmodule
bind adcsq_top adcsq_monitor mon (.ref_clk(ref_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .mux_sel(mux_sel), .sample_en(sample_en),
  .dac_code(dac_code), .pump_clk_sel(pump_clk_sel));
